// file: hw/lbc_fault_capture.v
`timescale 1ns/1ns
`default_nettype none
`include "lbc_map.vh"

// ==========================================================
// sticky fault capture, read-only to the host
module lbc_fault_capture #(
    parameter WIDTH = 8
) (
    input wire clk_in,
    input wire clear_in,
    input wire [WIDTH-1:0] event_in,
    output reg [WIDTH-1:0] flags_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // set wins over the reset clear so no event is lost
            always @(posedge clk_in) begin
                if (event_in[i]) begin
                    flags_out[i] <= 1'b1;
                end else if (clear_in) begin
                    flags_out[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // lbc_fault_capture
`default_nettype wire

// file: hw/lbc_map.vh
`ifndef LBC_MAP_VH
`define LBC_MAP_VH
// ==========================================================
// register offsets
`define LBC_ADDR_W 8
`define LBC_OFS_OUT_EN 8'h0A
`define LBC_OFS_FAULT 8'h0B
`define LBC_OFS_BIAS 8'h0C
// ==========================================================
// reset values
`define LBC_RST_OUT_EN 8'h00
`define LBC_RST_FAULT 8'h00
`define LBC_RST_BIAS 8'h18
// ==========================================================
// output-enable register fields
`define LBC_OE_SOFT_RESET 7
`define LBC_OE_OVP_ACTION 5
`define LBC_OE_SINK1 4
`define LBC_OE_BOTH 3
`define LBC_OE_FLASH_MODE 2
`define LBC_OE_FLASH_EN 1
`define LBC_OE_BACKLIGHT_OUTPUT_ENABLE 0
`define LBC_OE_WMASK 8'h3F
// ==========================================================
// fault register fields
`define LBC_FL_BACKLIGHT_OVERVOLTAGE_FLAG 7
`define LBC_FL_FLASH_OVERVOLTAGE_FLAG 6
`define LBC_FL_FLASH_OUTPUT_SHORT_FLAG 5
`define LBC_FL_VIN_MON 4
`define LBC_FL_FLASH_IRQ 3
`define LBC_FL_FLASH_LED_SHORT_FLAG 2
`define LBC_FL_FTIMEOUT 1
`define LBC_FL_THERMAL 0
// ==========================================================
// bias configuration fields
`define LBC_BI_WAKE 7
`define LBC_BI_RAMP 6
`define LBC_BI_AUTO_SEQUENCE_ENABLE 5
`define LBC_BI_POS_DISCH 4
`define LBC_BI_NEG_DISCH 3
`define LBC_BI_POS_EN 2
`define LBC_BI_NEG_EN 1
`define LBC_BI_PIN_SEL 0
// ==========================================================
// ramp times
`define LBC_RAMP_SLOW_US 800
`define LBC_RAMP_FAST_US 500
`endif

// file: hw/lbc_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "lbc_map.vh"

// What this block does
// R1: writing one to output-enable bit 7 returns all registers to defaults.
// R2: soft reset bit clears itself and reads zero afterwards.
// R3: bit 5 zero only flags overvoltage; one shuts the backlight down.
// R4: bit 4 enables sink one alone unless both-sinks enable overrides.
// R5: bit 3 enables both sinks; clear keeps sink two off.
// R6: bit 2 picks torch (zero, default) or flash (one) mode.
// R7: bit 1 enables the flash output, disabled at reset.
// R8: bit 0 enables the backlight output, disabled at reset.
// R9: fault bits 7 and 6 report backlight and flash overvoltage, read-only.
// R10: fault bit 5 reports flash output short, read-only, zero at reset.
// R11: fault bits 4..0 report monitor, interrupt, short, timeout, thermal flags.
// R12: bias bit 7 enables wake-up mode, disabled at reset.
// R13: ramp select picks 800 us when zero, 500 us when one.
// R14: bias bit 5 enables auto sequencing, disabled at reset.
// R15: bias bits 4 and 3 enable rail discharge, both reset to one.
// R16: bias bits 2 and 1 are register rail enables, reset disabled.
// R17: pin select one lets only the enable pins drive the rails.
// R18: pin select zero lets only register bits drive the rails.
// R19: fault bits are readable over the register port like all control.
// R20: reserved bits read zero and writes to them do nothing.
module lbc_regs #(
    parameter ADDR_W = `LBC_ADDR_W
) (
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [ADDR_W-1:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    output reg [7:0] REG_RDATA_OUT,
    output reg REG_RVALID_OUT,
    input wire BACKLIGHT_OVERVOLTAGE_FLAG_DET_IN,
    input wire FLASH_OVERVOLTAGE_FLAG_DET_IN,
    input wire FLASH_OUTPUT_SHORT_FLAG_DET_IN,
    input wire VIN_MON_DET_IN,
    input wire FLASH_IRQ_DET_IN,
    input wire FLASH_LED_SHORT_FLAG_DET_IN,
    input wire FTIMEOUT_DET_IN,
    input wire THERMAL_DET_IN,
    input wire POSITIVE_BIAS_ENABLE_PIN_IN,
    input wire NEGATIVE_BIAS_ENABLE_PIN_IN,
    output reg BACKLIGHT_OUTPUT_ENABLE_OUT,
    output reg SINK_ONE_ON_OUT,
    output reg SINK_TWO_ON_OUT,
    output reg FLASH_MODE_OUT,
    output reg FLASH_OUTPUT_ENABLE_OUT,
    output reg WAKE_UP_MODE_OUT,
    output reg RAMP_FAST_OUT,
    output reg AUTO_SEQUENCE_OUT,
    output reg POSITIVE_BIAS_DISCHARGE_OUT,
    output reg NEGATIVE_BIAS_DISCHARGE_OUT,
    output reg POSITIVE_BIAS_RAIL_ON_OUT,
    output reg NEGATIVE_BIAS_RAIL_ON_OUT
);
    // ==========================================================
    // ramp time constants for downstream use
    localparam integer RAMP_SLOW_US = `LBC_RAMP_SLOW_US; // R13
    localparam integer RAMP_FAST_US = `LBC_RAMP_FAST_US; // R13

    // ==========================================================
    // address decode
    function hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    reg [7:0] out_en_r;
    reg [7:0] bias_r;
    reg soft_rst_r;
    wire [7:0] fault_flags;
    wire [7:0] fault_events;
    wire any_rst;
    wire wr_oe;
    wire wr_bias;
    wire [7:0] out_en_nxt;
    wire bl_shutdown;

    // soft reset takes effect one edge after the write, then the bit reads zero
    assign any_rst = RST_IN | soft_rst_r; // R1
    assign wr_oe = REG_WR_IN & hit(REG_ADDR_IN, `LBC_OFS_OUT_EN);
    assign wr_bias = REG_WR_IN & hit(REG_ADDR_IN, `LBC_OFS_BIAS);
    // bit 7 and bit 6 never stored
    assign out_en_nxt = REG_WDATA_IN & `LBC_OE_WMASK; // R2 R20

    assign fault_events[`LBC_FL_BACKLIGHT_OVERVOLTAGE_FLAG] = BACKLIGHT_OVERVOLTAGE_FLAG_DET_IN; // R9
    assign fault_events[`LBC_FL_FLASH_OVERVOLTAGE_FLAG] = FLASH_OVERVOLTAGE_FLAG_DET_IN; // R9
    assign fault_events[`LBC_FL_FLASH_OUTPUT_SHORT_FLAG] = FLASH_OUTPUT_SHORT_FLAG_DET_IN; // R10
    assign fault_events[`LBC_FL_VIN_MON] = VIN_MON_DET_IN; // R11
    assign fault_events[`LBC_FL_FLASH_IRQ] = FLASH_IRQ_DET_IN; // R11
    assign fault_events[`LBC_FL_FLASH_LED_SHORT_FLAG] = FLASH_LED_SHORT_FLAG_DET_IN; // R11
    assign fault_events[`LBC_FL_FTIMEOUT] = FTIMEOUT_DET_IN; // R11
    assign fault_events[`LBC_FL_THERMAL] = THERMAL_DET_IN; // R11

    // ==========================================================
    // sticky fault register
    lbc_fault_capture #(
        .WIDTH(8)
    ) u_fault (
        .clk_in(CORE_CLK_IN),
        .clear_in(any_rst),
        .event_in(fault_events),
        .flags_out(fault_flags)
    );

    // ==========================================================
    // writable registers
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_oe & REG_WDATA_IN[`LBC_OE_SOFT_RESET]; // R1
        end
    end

    always @(posedge CORE_CLK_IN) begin
        if (any_rst) begin
            out_en_r <= `LBC_RST_OUT_EN; // R1 R6 R7 R8
            bias_r <= `LBC_RST_BIAS; // R12 R14 R15 R16 R18
        end else begin
            if (wr_oe) begin
                out_en_r <= out_en_nxt;
            end
            if (wr_bias) begin
                bias_r <= REG_WDATA_IN;
            end
        end
    end

    // ==========================================================
    // register readback; unmapped addresses read zero
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (!REG_RD_IN) begin
                REG_RDATA_OUT <= 8'h00;
            end else if (hit(REG_ADDR_IN, `LBC_OFS_OUT_EN)) begin
                REG_RDATA_OUT <= out_en_r; // R2 R20
            end else if (hit(REG_ADDR_IN, `LBC_OFS_FAULT)) begin
                REG_RDATA_OUT <= fault_flags; // R19
            end else if (hit(REG_ADDR_IN, `LBC_OFS_BIAS)) begin
                REG_RDATA_OUT <= bias_r;
            end else begin
                REG_RDATA_OUT <= 8'h00; // R20
            end
        end
    end

    // ==========================================================
    // control outputs
    // shutdown holds while bit 5 and the latched flag stay set, until a reset clears the flag or bit 5 is written zero
    assign bl_shutdown = out_en_r[`LBC_OE_OVP_ACTION] & fault_flags[`LBC_FL_BACKLIGHT_OVERVOLTAGE_FLAG]; // R3

    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            BACKLIGHT_OUTPUT_ENABLE_OUT <= 1'b0;
            SINK_ONE_ON_OUT <= 1'b0;
            SINK_TWO_ON_OUT <= 1'b0;
            FLASH_MODE_OUT <= 1'b0;
            FLASH_OUTPUT_ENABLE_OUT <= 1'b0;
            WAKE_UP_MODE_OUT <= 1'b0;
            RAMP_FAST_OUT <= 1'b0;
            AUTO_SEQUENCE_OUT <= 1'b0;
            POSITIVE_BIAS_DISCHARGE_OUT <= 1'b1;
            NEGATIVE_BIAS_DISCHARGE_OUT <= 1'b1;
            POSITIVE_BIAS_RAIL_ON_OUT <= 1'b0;
            NEGATIVE_BIAS_RAIL_ON_OUT <= 1'b0;
        end else begin
            BACKLIGHT_OUTPUT_ENABLE_OUT <= out_en_r[`LBC_OE_BACKLIGHT_OUTPUT_ENABLE] & ~bl_shutdown; // R8 R3
            SINK_ONE_ON_OUT <= out_en_r[`LBC_OE_SINK1] | out_en_r[`LBC_OE_BOTH]; // R4 R5
            SINK_TWO_ON_OUT <= out_en_r[`LBC_OE_BOTH]; // R5
            FLASH_MODE_OUT <= out_en_r[`LBC_OE_FLASH_MODE]; // R6
            FLASH_OUTPUT_ENABLE_OUT <= out_en_r[`LBC_OE_FLASH_EN]; // R7
            WAKE_UP_MODE_OUT <= bias_r[`LBC_BI_WAKE]; // R12
            RAMP_FAST_OUT <= bias_r[`LBC_BI_RAMP]; // R13
            AUTO_SEQUENCE_OUT <= bias_r[`LBC_BI_AUTO_SEQUENCE_ENABLE]; // R14
            POSITIVE_BIAS_DISCHARGE_OUT <= bias_r[`LBC_BI_POS_DISCH]; // R15
            NEGATIVE_BIAS_DISCHARGE_OUT <= bias_r[`LBC_BI_NEG_DISCH]; // R15
            if (bias_r[`LBC_BI_PIN_SEL]) begin
                POSITIVE_BIAS_RAIL_ON_OUT <= POSITIVE_BIAS_ENABLE_PIN_IN; // R17
                NEGATIVE_BIAS_RAIL_ON_OUT <= NEGATIVE_BIAS_ENABLE_PIN_IN; // R17
            end else begin
                POSITIVE_BIAS_RAIL_ON_OUT <= bias_r[`LBC_BI_POS_EN]; // R18 R16
                NEGATIVE_BIAS_RAIL_ON_OUT <= bias_r[`LBC_BI_NEG_EN]; // R18 R16
            end
        end
    end
endmodule // lbc_regs
`default_nettype wire

// file: verification/lbc_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// host strobing the register port
module lbc_host (
    input wire logic clk_in,
    output logic wr_out = 0,
    output logic rd_out = 0,
    output logic [7:0] addr_out = 0,
    output logic [7:0] wdata_out = 0
);
    // released bus shows inverted values, so a stale sample cannot pass
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_out = 1;
        addr_out = a;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
    task rd(input logic [7:0] a);
        @(negedge clk_in);
        rd_out = 1;
        addr_out = a;
        @(negedge clk_in);
        rd_out = 0;
        addr_out = ~a;
    endtask
endmodule // lbc_host
`default_nettype wire

// file: verification/lbc_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// port checks
module lbc_regs_monitor #(
    parameter ADDR_W = 8
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic REG_RVALID_OUT,
    input wire logic SINK_ONE_ON_OUT,
    input wire logic SINK_TWO_ON_OUT,
    input wire logic NEGATIVE_BIAS_DISCHARGE_OUT,
    input wire logic POSITIVE_BIAS_RAIL_ON_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence wr_oe;
        REG_WR_IN && REG_ADDR_IN == 8'h0A && !REG_WDATA_IN[7];
    endsequence
    sequence wr_bias;
        REG_WR_IN && REG_ADDR_IN == 8'h0C;
    endsequence
    // quiet bus after the reset write, else the lost write would muddle the check
    sequence wr_swr;
        REG_WR_IN && REG_ADDR_IN == 8'h0A && REG_WDATA_IN[7] ##1 !REG_WR_IN [*3];
    endsequence
    a_read_valid_pulse: assert property (REG_RD_IN |=> REG_RVALID_OUT) else $error("read gave no valid");
    a_idle_rdata_zero: assert property (!REG_RVALID_OUT |-> REG_RDATA_OUT == 8'h00) else $error("idle data not zero");
    a_oe_reserved_zero: assert property (REG_RD_IN && REG_ADDR_IN == 8'h0A |=> REG_RDATA_OUT[7:6] == 2'b00)
        else $error("top bits of enable register set");
    a_unmapped_read_zero: assert property (REG_RD_IN && (REG_ADDR_IN < 8'h0A || REG_ADDR_IN > 8'h0C)
        |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
    a_sink_one_follow: assert property (wr_oe |=> ##1 SINK_ONE_ON_OUT ==
        ($past(REG_WDATA_IN[4], 2) | $past(REG_WDATA_IN[3], 2))) else $error("sink one wrong");
    a_sink_two_follow: assert property (wr_oe |=> ##1 SINK_TWO_ON_OUT == $past(REG_WDATA_IN[3], 2))
        else $error("sink two wrong");
    a_rail_reg_follow: assert property (wr_bias ##0 !REG_WDATA_IN[0] |=> ##1
        POSITIVE_BIAS_RAIL_ON_OUT == $past(REG_WDATA_IN[2], 2)) else $error("rail not from register");
    a_discharge_follow: assert property (wr_bias |=> ##1 NEGATIVE_BIAS_DISCHARGE_OUT == $past(REG_WDATA_IN[3], 2))
        else $error("discharge wrong");
    a_soft_reset_default: assert property (wr_swr |=> !SINK_ONE_ON_OUT && NEGATIVE_BIAS_DISCHARGE_OUT)
        else $error("soft reset left outputs");
endmodule // lbc_regs_monitor
bind lbc_regs lbc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT), .SINK_ONE_ON_OUT(SINK_ONE_ON_OUT),
    .SINK_TWO_ON_OUT(SINK_TWO_ON_OUT), .NEGATIVE_BIAS_DISCHARGE_OUT(NEGATIVE_BIAS_DISCHARGE_OUT),
    .POSITIVE_BIAS_RAIL_ON_OUT(POSITIVE_BIAS_RAIL_ON_OUT));
`default_nettype wire

// file: verification/lbc_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench
module lbc_regs_test;
    logic clk = 0, rst = 1, wr, rd, rv, pp = 0, pn = 0;
    logic bl, s1, s2, fm, fe, wk, rf, au, pd, nd, pr, nr;
    logic [7:0] det = 0, addr, wdata, rdata, flg = 0, o = 0, b = 0, v;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 96938;
    int err_total = 0, checks_done = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    lbc_host u_host (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    lbc_regs u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rv), .BACKLIGHT_OVERVOLTAGE_FLAG_DET_IN(det[7]),
        .FLASH_OVERVOLTAGE_FLAG_DET_IN(det[6]), .FLASH_OUTPUT_SHORT_FLAG_DET_IN(det[5]), .VIN_MON_DET_IN(det[4]), .FLASH_IRQ_DET_IN(det[3]),
        .FLASH_LED_SHORT_FLAG_DET_IN(det[2]), .FTIMEOUT_DET_IN(det[1]), .THERMAL_DET_IN(det[0]),
        .POSITIVE_BIAS_ENABLE_PIN_IN(pp), .NEGATIVE_BIAS_ENABLE_PIN_IN(pn), .BACKLIGHT_OUTPUT_ENABLE_OUT(bl),
        .SINK_ONE_ON_OUT(s1), .SINK_TWO_ON_OUT(s2), .FLASH_MODE_OUT(fm), .FLASH_OUTPUT_ENABLE_OUT(fe),
        .WAKE_UP_MODE_OUT(wk), .RAMP_FAST_OUT(rf), .AUTO_SEQUENCE_OUT(au), .POSITIVE_BIAS_DISCHARGE_OUT(pd),
        .NEGATIVE_BIAS_DISCHARGE_OUT(nd), .POSITIVE_BIAS_RAIL_ON_OUT(pr), .NEGATIVE_BIAS_RAIL_ON_OUT(nr));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk_rd(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD rdata exp %h got %h", e, g);
        end
    endtask
    task chk_lvl(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    task outs();
        repeat (2) @(negedge clk);
        chk_lvl("bl", o[0] & ~(o[5] & flg[7]), bl);
        chk_lvl("s1", o[4] | o[3], s1);
        chk_lvl("s2", o[3], s2);
        chk_lvl("fm", o[2], fm);
        chk_lvl("fe", o[1], fe);
        chk_lvl("wk", b[7], wk);
        chk_lvl("rf", b[6], rf);
        chk_lvl("au", b[5], au);
        chk_lvl("pd", b[4], pd);
        chk_lvl("nd", b[3], nd);
        chk_lvl("pr", b[0] ? pp : b[2], pr);
        chk_lvl("nr", b[0] ? pn : b[1], nr);
    endtask
    always @(negedge clk) if (rv === 1'b1) chk_rd(exp_q.pop_front(), rdata);
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        rdx(8'h0A, 8'h00);
        rdx(8'h0B, 8'h00);
        rdx(8'h0C, 8'h18);
        rdx(8'h00, 8'h00);
        rdx(8'hFF, 8'h00);
        u_host.wr(8'h0B, 8'hFF);
        rdx(8'h0B, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            {pp, pn} = v[1:0];
            o = rnd() & 8'h7F;
            b = rnd() & ((i == 0) ? 8'hFE : 8'hFF);
            u_host.wr(8'h0A, o);
            u_host.wr(8'h0C, b);
            o = o & 8'h3F;
            rdx(8'h0A, o);
            rdx(8'h0C, b);
            outs();
        end
        $display("control outputs done");
        for (int i = 0; i < 8; i++) begin
            @(negedge clk) det = 8'h01 << i;
            flg |= det;
            @(negedge clk) det = 0;
            rdx(8'h0B, flg);
        end
        o = 8'h01;
        u_host.wr(8'h0A, o);
        outs();
        o = 8'h21;
        u_host.wr(8'h0A, o);
        outs();
        $display("faults and shutdown done");
        u_host.wr(8'h0A, 8'h80);
        repeat (4) @(negedge clk);
        {flg, o, b} = {8'h00, 8'h00, 8'h18};
        rdx(8'h0A, 8'h00);
        rdx(8'h0B, 8'h00);
        rdx(8'h0C, 8'h18);
        outs();
        $display("soft reset done");
        repeat (4) @(negedge clk);
        complete_run();
    end
endmodule // lbc_regs_test
`default_nettype wire
